// [hw/mrr_consts.vh]
// Constants for the move, rotate and return execution unit.
// Assumes a single core clock and the instruction word layout given below.
//
// Operation
// - Store accumulator into addressed file register; flags stay unchanged.
// - Move file register to accumulator (dest 0) or back to itself (dest 1).
// - Move file register sets zero flag from moved value, either way.
// - Return from interrupt pops stack top into PC, sets global enable.
// - Rotate left through carry: old carry to bit 0, bit 7 to carry.
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Return with literal loads accumulator, pops stack top; flags kept.
// - Return with literal takes two cycles; the following fetch is dropped.
`ifndef MRR_CONSTS_VH
`define MRR_CONSTS_VH

// ****************************************************************
// Instruction word layout
// ****************************************************************
`define MRR_INSTR_W      14
`define MRR_OPC_HI       13
`define MRR_OPC_LO       8
`define MRR_DEST_BIT     7
`define MRR_FADDR_HI     6
`define MRR_LIT_HI       7

// Opcode encodings; values are arbitrary for this unit
`define MRR_OP_NO_OP     6'h00
`define MRR_OP_STORE     6'h01
`define MRR_OP_MOVE      6'h02
`define MRR_OP_RET_INT   6'h03
`define MRR_OP_ROT_L     6'h04
`define MRR_OP_ROT_R     6'h05
`define MRR_OP_RET_LIT   6'h06

// ****************************************************************
// Register port map
// ****************************************************************
`define MRR_ADDR_ACC     8'h80
`define MRR_ADDR_STAT    8'h81
`define MRR_FILE_SEL     7
`define MRR_STAT_C       0
`define MRR_STAT_Z       1
`define MRR_STAT_IE      2

// ****************************************************************
// Reset values
// ****************************************************************
`define MRR_RST_BYTE     8'h00
`define MRR_RST_BIT      1'b0
`define MRR_RST_READY    1'b1

`endif

// [hw/mrr_exec.v]
// Execution unit for store, move, no-op, rotate and return instructions.
// Assumes instructions, stack top and register port all on sys_clk; the
// return stack itself and the fetch logic live outside.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "mrr_consts.vh"

module mrr_exec
#(
   parameter PC_W = 13
)
(
   input  wire                   sys_clk,
   input  wire                   rst,
   input  wire                   instr_valid,
   input  wire [`MRR_INSTR_W-1:0] instr,
   input  wire [PC_W-1:0]        stack_top_entry,
   input  wire [7:0]             reg_addr,
   input  wire [7:0]             reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [7:0]             reg_rdata,
   output reg                    instr_ready,
   output reg                    retire,
   output reg                    stack_pop,
   output reg                    pc_load,
   output reg  [PC_W-1:0]        pc_value,
   output reg  [7:0]             accum,
   output reg                    carry,
   output reg                    zero,
   output reg                    global_interrupt_enable
);

   // ****************************************************************
   // Decode
   // ****************************************************************
   reg  [7:0] file_mem [0:127];

   wire [5:0] opc   = instr[`MRR_OPC_HI:`MRR_OPC_LO];
   wire       dest  = instr[`MRR_DEST_BIT];
   wire [6:0] faddr = instr[`MRR_FADDR_HI:0];
   wire [7:0] lit   = instr[`MRR_LIT_HI:0];
   wire       take  = instr_valid & instr_ready;

   wire is_no_op   = take & (opc == `MRR_OP_NO_OP);
   wire is_store   = take & (opc == `MRR_OP_STORE);
   wire is_move    = take & (opc == `MRR_OP_MOVE);
   wire is_ret_int = take & (opc == `MRR_OP_RET_INT);
   wire is_rot_l   = take & (opc == `MRR_OP_ROT_L);
   wire is_rot_r   = take & (opc == `MRR_OP_ROT_R);
   wire is_ret_lit = take & (opc == `MRR_OP_RET_LIT);
   wire is_rot     = is_rot_l | is_rot_r;
   wire is_ret     = is_ret_int | is_ret_lit;

   wire [7:0] fval  = file_mem[faddr];
   wire [7:0] rot_l = {fval[6:0], carry};
   wire [7:0] rot_r = {carry, fval[7:1]};

   // Result byte of the data-moving instructions
   reg  [7:0] result;
   always @*
   begin
      result = fval;
      if (is_store)
      begin
         result = accum;
      end
      else if (is_rot_l)
      begin
         result = rot_l;
      end
      else if (is_rot_r)
      begin
         result = rot_r;
      end
   end

   // Destination selection; dest 1 writes the same file register back
   wire exec_file_we = is_store
                       | ((is_move | is_rot) & dest);
   wire exec_acc_we  = (is_move | is_rot) & ~dest;

   // ****************************************************************
   // Register port decode
   // ****************************************************************
   wire bus_file  = ~reg_addr[`MRR_FILE_SEL];
   wire bus_acc   = reg_wr & (reg_addr == `MRR_ADDR_ACC);
   wire bus_stat  = reg_wr & (reg_addr == `MRR_ADDR_STAT);
   // Single write port: an instruction write beats a port write
   wire bus_fwe   = reg_wr & bus_file & ~exec_file_we;

   // File memory, no reset so it maps onto plain RAM
   always @(posedge sys_clk)
   begin
      if (exec_file_we)
      begin
         file_mem[faddr] <= result;
      end
      else if (bus_fwe)
      begin
         file_mem[reg_addr[`MRR_FADDR_HI:0]] <= reg_wdata;
      end
   end

   // ****************************************************************
   // Accumulator, flags and program flow
   // ****************************************************************
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         accum                   <= `MRR_RST_BYTE;
         carry                   <= `MRR_RST_BIT;
         zero                    <= `MRR_RST_BIT;
         global_interrupt_enable <= `MRR_RST_BIT;
         instr_ready             <= `MRR_RST_READY;
         retire                  <= `MRR_RST_BIT;
         stack_pop               <= `MRR_RST_BIT;
         pc_load                 <= `MRR_RST_BIT;
         pc_value                <= {PC_W{1'b0}};
      end
      else
      begin
         // Accumulator: instruction updates win over port writes
         if (is_ret_lit)
         begin
            accum <= lit;
         end
         else if (exec_acc_we)
         begin
            accum <= result;
         end
         else if (bus_acc)
         begin
            accum <= reg_wdata;
         end

         // Carry moves only on rotates and status port writes; store and returns leave it
         if (is_rot_l)
         begin
            carry <= fval[7];
         end
         else if (is_rot_r)
         begin
            carry <= fval[0];
         end
         else if (bus_stat)
         begin
            carry <= reg_wdata[`MRR_STAT_C];
         end

         // Zero follows the moved value whichever way it went
         if (is_move)
         begin
            zero <= (fval == `MRR_RST_BYTE);
         end
         else if (bus_stat)
         begin
            zero <= reg_wdata[`MRR_STAT_Z];
         end

         // Set from the return wins over a same-cycle software clear
         if (is_ret_int)
         begin
            global_interrupt_enable <= 1'b1;
         end
         else if (bus_stat)
         begin
            global_interrupt_enable <= reg_wdata[`MRR_STAT_IE];
         end

         // Returns pop the stack and redirect the PC in one step
         stack_pop <= is_ret;
         pc_load   <= is_ret;
         if (is_ret)
         begin
            pc_value <= stack_top_entry;
         end

         // The fetch after a return is stale, so drop one cycle
         instr_ready <= ~is_ret;
         // A no-op retires and touches nothing else
         retire <= is_no_op | is_store | is_move | is_rot | is_ret;
      end
   end

   // ****************************************************************
   // Register port read, one cycle after the strobe
   // ****************************************************************
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         reg_rdata <= `MRR_RST_BYTE;
      end
      else if (reg_rd)
      begin
         if (bus_file)
         begin
            reg_rdata <= file_mem[reg_addr[`MRR_FADDR_HI:0]];
         end
         else if (reg_addr == `MRR_ADDR_ACC)
         begin
            reg_rdata <= accum;
         end
         else if (reg_addr == `MRR_ADDR_STAT)
         begin
            reg_rdata <= {5'h00, global_interrupt_enable, zero, carry};
         end
         else
         begin
            reg_rdata <= `MRR_RST_BYTE;       // Unmapped reads as zero
         end
      end
      else
      begin
         reg_rdata <= `MRR_RST_BYTE;
      end
   end

endmodule
`default_nettype wire

// [testbench/mrr_exec_properties.sv]
// Port-level assertions for the move, rotate and return unit.
// Assumes it is bound into every mrr_exec on one clock.
`timescale 1ns/1ns
`default_nettype none
`include "mrr_consts.vh"
module mrr_exec_props
#(
   parameter PC_W = 13
)
(
   input wire                    sys_clk,
   input wire                    rst,
   input wire                    instr_valid,
   input wire [`MRR_INSTR_W-1:0] instr,
   input wire [PC_W-1:0]         stack_top_entry,
   input wire                    reg_wr,
   input wire                    instr_ready,
   input wire                    retire,
   input wire                    stack_pop,
   input wire                    pc_load,
   input wire [PC_W-1:0]         pc_value,
   input wire [7:0]              accum,
   input wire                    carry,
   input wire                    zero,
   input wire                    global_interrupt_enable
);
   // ********
   // Taken instruction decode
   // ********
   wire [5:0] opc = instr[`MRR_OPC_HI:`MRR_OPC_LO];
   // Port writes may legally override flags, so leave those cycles out
   wire       tk  = instr_valid && instr_ready && !reg_wr;
   wire       ret = tk && (opc == `MRR_OP_RET_INT || opc == `MRR_OP_RET_LIT);
   wire       d0  = !instr[`MRR_DEST_BIT];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_ret_pop_pc: assert property (ret |=> stack_pop && pc_load
      && pc_value == $past(stack_top_entry)) else $error("return pop bad");
   a_ret_two_cycle: assert property (ret
      |=> !instr_ready ##1 instr_ready) else $error("return not two cycles");
   a_lit_to_acc: assert property (tk && opc == `MRR_OP_RET_LIT
      |=> accum == $past(instr[7:0])) else $error("literal not loaded");
   a_int_en_set: assert property (tk && opc == `MRR_OP_RET_INT
      |=> global_interrupt_enable) else $error("enable not set");
   a_ret_flags_kept: assert property (ret
      |=> $stable({carry, zero})) else $error("return changed flags");
   a_idle_quiet: assert property (tk && opc == `MRR_OP_NO_OP
      |=> retire && !stack_pop && $stable({accum, carry, zero}))
      else $error("no-op acted");
   a_store_keeps: assert property (tk && opc == `MRR_OP_STORE
      |=> $stable({accum, carry, zero})) else $error("store changed state");
   a_move_zero: assert property (tk && opc == `MRR_OP_MOVE && d0
      |=> zero == (accum == 8'h00)) else $error("move zero flag bad");
   a_rotl_bit_in: assert property (tk && opc == `MRR_OP_ROT_L && d0
      |=> accum[0] == $past(carry) && $stable(zero))
      else $error("left rotate bad");
   a_rotr_bit_in: assert property (tk && opc == `MRR_OP_ROT_R && d0
      |=> accum[7] == $past(carry) && $stable(zero))
      else $error("right rotate bad");
   c_ret: cover property (ret);
   c_move: cover property (tk && opc == `MRR_OP_MOVE);
   c_rot: cover property (tk && opc == `MRR_OP_ROT_R);
endmodule
bind mrr_exec mrr_exec_props #(.PC_W(PC_W)) u_props (.sys_clk(sys_clk),
   .rst(rst), .instr_valid(instr_valid), .instr(instr), .reg_wr(reg_wr),
   .stack_top_entry(stack_top_entry), .instr_ready(instr_ready),
   .retire(retire), .stack_pop(stack_pop), .pc_load(pc_load),
   .pc_value(pc_value), .accum(accum), .carry(carry), .zero(zero),
   .global_interrupt_enable(global_interrupt_enable));
`default_nettype wire

// [testbench/tb_move_rotate_return_exec.sv]
// Directed bench: instruction words and register port traffic.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ns
`default_nettype none
`include "mrr_consts.vh"
module tb_move_rotate_return_exec;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        instr_valid = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic [12:0] stack_top_entry = 13'h0000;
   logic [7:0]  reg_addr = 8'h00;
   logic [7:0]  reg_wdata = 8'h00;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   wire  [7:0]  reg_rdata, accum;
   wire  [12:0] pc_value;
   wire         instr_ready, retire, stack_pop, pc_load, carry, zero, int_en;
   wire  [2:0]  st = {int_en, zero, carry};
   // Handshake outputs seen in the cycle after an instruction is taken
   logic [3:0]  pulses = 4'h0;
   int          miscompares = 0;
   int          n_tests = 0;
   mrr_exec #(.PC_W(13)) u_dut (.sys_clk(sys_clk), .rst(rst),
      .instr_valid(instr_valid), .instr(instr), .reg_addr(reg_addr),
      .stack_top_entry(stack_top_entry), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .instr_ready(instr_ready), .retire(retire), .stack_pop(stack_pop),
      .pc_load(pc_load), .pc_value(pc_value), .accum(accum),
      .carry(carry), .zero(zero), .global_interrupt_enable(int_en));
   // ********
   // Clock, helpers
   // ********
   initial forever #2 sys_clk = ~sys_clk;
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // An extra idle edge keeps a strobe from being set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      // Data launched by the strobe edge still stands at this edge
      @(posedge sys_clk);
      chk(reg_rdata, e);
   endtask
   // Two idle edges cover the stall after a return
   task automatic ex(input logic [5:0] op, input logic [7:0] lo);
      instr_valid <= 1'b1;
      instr <= {op, lo};
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      @(posedge sys_clk);
      pulses = {retire, stack_pop, pc_load, instr_ready};
      @(posedge sys_clk);
   endtask
   initial
   begin
      #4000 miscompares++;
      results();
   end
   initial
   begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk({accum, 4'h0, instr_ready, st}, 16'h0008);
      wr(`MRR_ADDR_ACC, 8'h5a);
      ex(`MRR_OP_STORE, 8'h7f);
      chk(pulses, 4'h9);
      rd(8'h7f, 8'h5a);
      chk(st, 3'h0);
      $display("store test done");
      wr(8'h10, 8'h00);
      ex(`MRR_OP_MOVE, 8'h10);
      chk({accum, 5'h00, st}, 16'h0002);
      ex(`MRR_OP_MOVE, 8'hff);
      chk({accum, 5'h00, st}, 16'h0000);
      rd(8'h7f, 8'h5a);
      $display("move test done");
      wr(`MRR_ADDR_STAT, 8'h01);
      ex(`MRR_OP_ROT_L, 8'hff);
      rd(8'h7f, 8'hb5);
      chk(st, 3'h0);
      ex(`MRR_OP_ROT_L, 8'h7f);
      chk({accum, 5'h00, st}, 16'h6a01);
      ex(`MRR_OP_ROT_R, 8'h7f);
      chk({accum, 5'h00, st}, 16'hda01);
      ex(`MRR_OP_ROT_R, 8'hff);
      rd(8'h7f, 8'hda);
      $display("rotate test done");
      ex(`MRR_OP_NO_OP, 8'h00);
      chk(pulses, 4'h9);
      chk({accum, 5'h00, st}, 16'hda01);
      stack_top_entry <= 13'h0abc;
      ex(`MRR_OP_RET_LIT, 8'hc3);
      chk(pulses, 4'he);
      chk(pc_value, 16'h0abc);
      chk({accum, 5'h00, st}, 16'hc301);
      stack_top_entry <= 13'h0123;
      ex(`MRR_OP_RET_INT, 8'h00);
      chk(pulses, 4'he);
      chk(pc_value, 16'h0123);
      rd(`MRR_ADDR_STAT, 8'h05);
      $display("return test done");
      // A mid-run reset must bring accum, instr_ready and the flags back to their idle values
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk({accum, 4'h0, instr_ready, st}, 16'h0008);
      $display("reset test done");
      wr(8'h90, 8'hff);
      rd(8'h90, 8'h00);
      rd(8'h82, 8'h00);
      $display("port test done");
      results();
   end
endmodule
`default_nettype wire
